// ### hw/pin_sync.sv
// two-stage synchroniser for pin levels
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] nxt_meta;
   logic [WIDTH-1:0] nxt_sync;

   always_comb begin
      nxt_meta = async_i;
      nxt_sync = meta_ff;
   end

   // reset value 1 keeps active-low wake lines idle
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign sync_o = sync_ff;
endmodule : pin_sync

// ### hw/port2_port5_io_mux.sv
// apb register block and pin muxing for port 2 and port 5
// assumes serial unit control bits and port 5 output data arrive on mclk_i
`timescale 1ns/10ps
`include "port_io_params.svh"
// Summary of operation
// - port 2 data bits 7..3 always read 1, writes ignored
// - port 2 data bits 2..0 are read/write output values, reset 0
// - direction 1 means data read returns stored value
// - direction 0 means data read returns synced pin level
// - tx select set makes pin 2 the serial transmit output
// - receiver enable set makes pin 1 the serial receive input
// - pin 0 is clock input, clock output, or gpio by clock bits
// - a selected peripheral function overrides the pin's direction bit for drive; data reads still follow the direction bit
// - port 5 pins also carry wake inputs and converter trigger
// - port 5 function select is read/write, resets to zero
// - select bits 7,6 choose push-pull or nmos open-drain drive
// - select bit 5 routes pin 5 to wake 5 and trigger
// - select bits 4..0 make pins wake inputs 4..0
// - port 5 direction is write-only, resets to all inputs
// - in gpio use direction 1 drives output, 0 is input
// - port 5 direction ignored while pin is a wake or trigger input
// - port 2 direction is write-only, reset 0, 1 means output
// - serial and port 1 mode settings outrank gpio on port 2
module port2_port5_io_mux (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire port_io_pkg::apb_addr_t paddr_i,
   input wire port_io_pkg::apb_data_t pwdata_i,
   output port_io_pkg::apb_data_t prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic tx_select_i,
   input wire logic rx_enable_bit_i,
   input wire logic clock_source_hi_i,
   input wire logic clock_source_lo_i,
   input wire logic clocked_mode_i,
   input wire logic serial_txd_i,
   input wire logic serial_clk_out_i,
   output logic serial_rxd_o,
   output logic serial_clk_in_o,
   input wire port_io_pkg::port2_vec_t p2_pin_i,
   output port_io_pkg::port2_vec_t p2_pin_o,
   output port_io_pkg::port2_vec_t p2_pin_oe_n_o,
   input wire port_io_pkg::port5_vec_t p5_out_data_i,
   input wire port_io_pkg::port5_vec_t p5_pin_i,
   output port_io_pkg::port5_vec_t p5_pin_o,
   output port_io_pkg::port5_vec_t p5_pin_oe_n_o,
   output port_io_pkg::port5_vec_t p5_pin_level_o,
   output port_io_pkg::wake_vec_t wake_in_n_o,
   output logic conv_trigger_in_n_o
);
   import port_io_pkg::*;

   port2_vec_t port2_data_ff;
   port2_vec_t port2_direction_ff;
   port5_vec_t port5_function_select_ff;
   port5_vec_t port5_direction_ff;
   apb_data_t prdata_ff;
   logic pslverr_ff;
   port2_vec_t nxt_port2_data;
   port2_vec_t nxt_port2_direction;
   port5_vec_t nxt_port5_function_select;
   port5_vec_t nxt_port5_direction;
   apb_data_t nxt_prdata;
   logic nxt_pslverr;

   port2_vec_t p2_sync;
   port5_vec_t p5_sync;
   port2_vec_t p2_readback;
   pin_role_t clk_role;
   logic setup_phase;
   logic access_phase;

   function automatic logic addr_mapped(input apb_addr_t addr);
      addr_mapped = (addr == `PORT2_DATA_OFS) || (addr == `PORT2_DIRECTION_OFS) ||
                    (addr == `PORT5_FUNCTION_SELECT_OFS) || (addr == `PORT5_DIRECTION_OFS);
   endfunction : addr_mapped

   pin_sync #(
      .WIDTH(`PORT2_WIDTH)
   ) u_p2_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .async_i(p2_pin_i),
      .sync_o(p2_sync)
   );

   pin_sync #(
      .WIDTH(`PORT5_WIDTH)
   ) u_p5_sync (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .async_i(p5_pin_i),
      .sync_o(p5_sync)
   );

   assign setup_phase = psel_i && !penable_i;
   assign access_phase = psel_i && penable_i;

   // zero-wait slave: read data is captured in setup, so access always completes
   assign pready_o = access_phase;
   assign prdata_o = prdata_ff;
   assign pslverr_o = pslverr_ff && access_phase;

   always_comb begin
      for (int i = 0; i < `PORT2_WIDTH; i++) begin
         p2_readback[i] = port2_direction_ff[i] ? port2_data_ff[i] : p2_sync[i];
      end
   end

   always_comb begin
      nxt_port2_data = port2_data_ff;
      nxt_port2_direction = port2_direction_ff;
      nxt_port5_function_select = port5_function_select_ff;
      nxt_port5_direction = port5_direction_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      if (setup_phase) begin
         nxt_pslverr = !addr_mapped(paddr_i);
         nxt_prdata = '0;
         if (!pwrite_i) begin
            unique case (paddr_i)
               `PORT2_DATA_OFS: nxt_prdata = {24'h0, `PORT2_RSVD_ONES, p2_readback};
               `PORT5_FUNCTION_SELECT_OFS: nxt_prdata = {24'h0, port5_function_select_ff};
               // direction registers are write-only and read as zero
               default: nxt_prdata = '0;
            endcase
         end
      end
      if (access_phase && pwrite_i) begin
         unique case (paddr_i)
            `PORT2_DATA_OFS: nxt_port2_data = pwdata_i[2:0];
            `PORT2_DIRECTION_OFS: nxt_port2_direction = pwdata_i[2:0];
            `PORT5_FUNCTION_SELECT_OFS: nxt_port5_function_select = pwdata_i[7:0];
            `PORT5_DIRECTION_OFS: nxt_port5_direction = pwdata_i[7:0];
            default: nxt_port2_data = port2_data_ff;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         port2_data_ff <= `PORT2_DATA_RST;
         port2_direction_ff <= `PORT2_DIRECTION_RST;
         port5_function_select_ff <= `PORT5_FUNCTION_SELECT_RST;
         port5_direction_ff <= `PORT5_DIRECTION_RST;
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end else begin
         port2_data_ff <= nxt_port2_data;
         port2_direction_ff <= nxt_port2_direction;
         port5_function_select_ff <= nxt_port5_function_select;
         port5_direction_ff <= nxt_port5_direction;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // clock pin: external clock input outranks clock output
   always_comb begin
      if (clock_source_hi_i) begin
         clk_role = ROLE_PERIPH_IN;
      end else if (clock_source_lo_i || clocked_mode_i) begin
         clk_role = ROLE_PERIPH_OUT;
      end else begin
         clk_role = ROLE_GPIO;
      end
   end

   always_comb begin
      p2_pin_o = '0;
      p2_pin_oe_n_o = '1;
      if (tx_select_i) begin
         p2_pin_o[`P2_TX_PIN] = serial_txd_i;
         p2_pin_oe_n_o[`P2_TX_PIN] = 1'b0;
      end else begin
         p2_pin_o[`P2_TX_PIN] = port2_data_ff[`P2_TX_PIN];
         p2_pin_oe_n_o[`P2_TX_PIN] = !port2_direction_ff[`P2_TX_PIN];
      end
      if (!rx_enable_bit_i) begin
         p2_pin_o[`P2_RX_PIN] = port2_data_ff[`P2_RX_PIN];
         p2_pin_oe_n_o[`P2_RX_PIN] = !port2_direction_ff[`P2_RX_PIN];
      end
      unique case (clk_role)
         ROLE_PERIPH_OUT: begin
            p2_pin_o[`P2_CLK_PIN] = serial_clk_out_i;
            p2_pin_oe_n_o[`P2_CLK_PIN] = 1'b0;
         end
         ROLE_GPIO: begin
            p2_pin_o[`P2_CLK_PIN] = port2_data_ff[`P2_CLK_PIN];
            p2_pin_oe_n_o[`P2_CLK_PIN] = !port2_direction_ff[`P2_CLK_PIN];
         end
         ROLE_PERIPH_IN: begin
            p2_pin_o[`P2_CLK_PIN] = 1'b0;
         end
      endcase
   end

   // receive input idles high and clock input idles low when their pin is not assigned to the serial unit
   assign serial_rxd_o = rx_enable_bit_i ? p2_sync[`P2_RX_PIN] : 1'b1;
   assign serial_clk_in_o = (clk_role == ROLE_PERIPH_IN) ? p2_sync[`P2_CLK_PIN] : 1'b0;

   port5_pin_mux u_p5_mux (
      .function_select_i(port5_function_select_ff),
      .direction_i(port5_direction_ff),
      .out_data_i(p5_out_data_i),
      .pin_o(p5_pin_o),
      .pin_oe_n_o(p5_pin_oe_n_o)
   );

   assign p5_pin_level_o = p5_sync;

   // wake and trigger lines are active low, held high when not selected
   always_comb begin
      for (int i = 0; i < `WAKE_WIDTH; i++) begin
         wake_in_n_o[i] = port5_function_select_ff[i] ? p5_sync[i] : 1'b1;
      end
      conv_trigger_in_n_o = port5_function_select_ff[`P5_TRIG_PIN] ?
                            p5_sync[`P5_TRIG_PIN] : 1'b1;
   end
endmodule : port2_port5_io_mux

// ### hw/port5_pin_mux.sv
// port 5 pad drive: push-pull, open-drain or wake/trigger input per pin
// assumes registers and output data come from logic on the same clock
`timescale 1ns/10ps
`include "port_io_params.svh"
module port5_pin_mux (
   input wire port_io_pkg::port5_vec_t function_select_i,
   input wire port_io_pkg::port5_vec_t direction_i,
   input wire port_io_pkg::port5_vec_t out_data_i,
   output port_io_pkg::port5_vec_t pin_o,
   output port_io_pkg::port5_vec_t pin_oe_n_o
);
   import port_io_pkg::*;

   always_comb begin
      pin_o = '0;
      pin_oe_n_o = '1;
      for (int i = 0; i < `PORT5_WIDTH; i++) begin
         if (i >= `P5_OD_LO) begin
            if (direction_i[i]) begin
               if (function_select_i[i]) begin
                  // open drain: only a low is driven, a high floats
                  pin_o[i] = 1'b0;
                  pin_oe_n_o[i] = out_data_i[i];
               end else begin
                  pin_o[i] = out_data_i[i];
                  pin_oe_n_o[i] = 1'b0;
               end
            end
         end else if (!function_select_i[i] && direction_i[i]) begin
            pin_o[i] = out_data_i[i];
            pin_oe_n_o[i] = 1'b0;
         end
      end
   end
endmodule : port5_pin_mux

// ### hw/port_io_params.svh
// register map, field positions and reset values of the port 2 / port 5 block
// assumes byte addressing on a 32-bit apb bus, one word per register
`ifndef PORT_IO_PARAMS_SVH
`define PORT_IO_PARAMS_SVH

`define PORT2_DATA_OFS 8'h00
`define PORT2_DIRECTION_OFS 8'h04
`define PORT5_FUNCTION_SELECT_OFS 8'h08
`define PORT5_DIRECTION_OFS 8'h0c

`define PORT2_WIDTH 3
`define PORT5_WIDTH 8
`define WAKE_WIDTH 6

`define PORT2_RSVD_ONES 5'h1f
`define PORT2_DATA_RST 3'h0
`define PORT2_DIRECTION_RST 3'h0
`define PORT5_FUNCTION_SELECT_RST 8'h00
`define PORT5_DIRECTION_RST 8'h00

`define P2_TX_PIN 2
`define P2_RX_PIN 1
`define P2_CLK_PIN 0
`define P5_TRIG_PIN 5
`define P5_OD_LO 6

`endif

// ### hw/port_io_pkg.sv
// types shared by the port 2 / port 5 block
// assumes port_io_params.svh is compiled alongside
package port_io_pkg;
   typedef logic [7:0] apb_addr_t;
   typedef logic [31:0] apb_data_t;
   typedef logic [2:0] port2_vec_t;
   typedef logic [7:0] port5_vec_t;
   typedef logic [5:0] wake_vec_t;
   typedef enum logic [1:0] {
      ROLE_GPIO,
      ROLE_PERIPH_IN,
      ROLE_PERIPH_OUT
   } pin_role_t;
endpackage : port_io_pkg

// ### verification/board_model.sv
// board pads and serial unit as seen from the port block
// assumes one clock; board levels come from the bench
`timescale 1ns/10ps
module board_model (
   input wire logic mclk_i,
   input wire logic [2:0] p2_ext_i,
   input wire logic [7:0] p5_ext_i,
   input wire logic [2:0] p2_out_i,
   input wire logic [2:0] p2_oe_n_i,
   input wire logic [7:0] p5_out_i,
   input wire logic [7:0] p5_oe_n_i,
   output logic [2:0] p2_pad_o,
   output logic [7:0] p5_pad_o,
   output logic txd_o,
   output logic sck_o
);
   logic txd_ff = 1'b0;
   logic sck_ff = 1'b1;
   // serial stand-in toggles every cycle so a stuck mux shows
   always @(posedge mclk_i) begin
      txd_ff <= ~txd_ff;
      sck_ff <= ~sck_ff;
   end
   assign txd_o = txd_ff;
   assign sck_o = sck_ff;
   // released pads fall back to the board level
   assign p2_pad_o = (p2_oe_n_i & p2_ext_i) | (~p2_oe_n_i & p2_out_i);
   assign p5_pad_o = (p5_oe_n_i & p5_ext_i) | (~p5_oe_n_i & p5_out_i);
endmodule : board_model

// ### verification/port_io_sva.sv
// checker: port 2 serial muxing, port 5 input routing, pin synchronisers
// assumes it is bound into port2_port5_io_mux and sees its ports only
`timescale 1ns/10ps
module port_io_sva (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic tx_select_i,
   input wire logic rx_enable_bit_i,
   input wire logic clock_source_hi_i,
   input wire logic clock_source_lo_i,
   input wire logic clocked_mode_i,
   input wire logic serial_txd_i,
   input wire logic serial_clk_out_i,
   input wire logic serial_rxd_o,
   input wire port_io_pkg::port2_vec_t p2_pin_i,
   input wire port_io_pkg::port2_vec_t p2_pin_o,
   input wire port_io_pkg::port2_vec_t p2_pin_oe_n_o,
   input wire port_io_pkg::port5_vec_t p5_pin_i,
   input wire port_io_pkg::port5_vec_t p5_pin_oe_n_o,
   input wire port_io_pkg::port5_vec_t p5_pin_level_o,
   input wire port_io_pkg::wake_vec_t wake_in_n_o,
   input wire logic conv_trigger_in_n_o
);
   import port_io_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // both sync stages loaded since reset left
   sequence s_quiet2;
      !reset_i ##1 !reset_i;
   endsequence
   chk_tx_drive: assert property (
      tx_select_i |-> !p2_pin_oe_n_o[2] && p2_pin_o[2] == serial_txd_i)
      else $error("pin 2 not driving transmit data");
   chk_rx_input: assert property (
      rx_enable_bit_i |-> p2_pin_oe_n_o[1]) else $error("pin 1 driven in receive use");
   chk_clk_input: assert property (
      clock_source_hi_i |-> p2_pin_oe_n_o[0]) else $error("pin 0 driven as clock input");
   chk_clk_drive: assert property (
      !clock_source_hi_i && (clock_source_lo_i || clocked_mode_i)
      |-> !p2_pin_oe_n_o[0] && p2_pin_o[0] == serial_clk_out_i)
      else $error("pin 0 not driving serial clock");
   chk_rx_sync: assert property (
      s_quiet2 ##1 rx_enable_bit_i |-> serial_rxd_o == $past(p2_pin_i[1], 2))
      else $error("receive line not two flops behind pin");
   chk_level_sync: assert property (
      s_quiet2 |=> p5_pin_level_o == $past(p5_pin_i, 2)) else $error("port 5 level delay wrong");
   chk_wake_undriven: assert property (
      &(wake_in_n_o | p5_pin_oe_n_o[5:0])) else $error("wake pin is being driven");
   chk_trig_pair: assert property (
      !conv_trigger_in_n_o |-> !wake_in_n_o[5]) else $error("trigger without wake 5");
endmodule : port_io_sva
bind port2_port5_io_mux port_io_sva i_sva (.*);

// ### verification/testbench.sv
// self-checking bench for the port 2 / port 5 block
// assumes zero-wait apb slave and two-flop pin synchronisers
`timescale 1ns/10ps
`include "port_io_params.svh"
module testbench;
   import port_io_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   apb_addr_t paddr_i = 8'h00;
   apb_data_t pwdata_i = 32'h0, prdata_o;
   logic pready_o, pslverr_o, serial_rxd_o, serial_clk_in_o, conv_trigger_in_n_o;
   logic tx_select_i = 1'b0, rx_enable_bit_i = 1'b0, clock_source_hi_i = 1'b0;
   logic clock_source_lo_i = 1'b0, clocked_mode_i = 1'b0, serial_txd_i, serial_clk_out_i;
   port2_vec_t p2_pin_i, p2_pin_o, p2_pin_oe_n_o, p2_ext = 3'h5;
   port5_vec_t p5_out_data_i = 8'h0f, p5_pin_i, p5_pin_o, p5_pin_oe_n_o, p5_pin_level_o;
   port5_vec_t p5_ext = 8'hff;
   wake_vec_t wake_in_n_o;
   int errors = 0, comparisons = 0;
   always #4 mclk_i = ~mclk_i;
   port2_port5_io_mux i_dut (.*);
   board_model i_board (.mclk_i(mclk_i), .p2_ext_i(p2_ext), .p5_ext_i(p5_ext),
      .p2_out_i(p2_pin_o), .p2_oe_n_i(p2_pin_oe_n_o), .p5_out_i(p5_pin_o),
      .p5_oe_n_i(p5_pin_oe_n_o), .p2_pad_o(p2_pin_i), .p5_pad_o(p5_pin_i),
      .txd_o(serial_txd_i), .sck_o(serial_clk_out_i));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask : step
   task automatic apb(input logic wr, input apb_addr_t a, input apb_data_t wd,
         output apb_data_t rd, output logic err);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      @(posedge mclk_i);
      while (pready_o !== 1'b1) @(posedge mclk_i);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic wr(input apb_addr_t a, input apb_data_t d);
      apb_data_t r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input string what, input apb_addr_t a, input apb_data_t x, input logic xe);
      apb_data_t r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(what, r, x);
      check({what, " err"}, {31'h0, e}, {31'h0, xe});
   endtask : rd
   task automatic t_reset_vals;
      check("p2 oe", p2_pin_oe_n_o, 3'h7);
      check("p5 oe", p5_pin_oe_n_o, 8'hff);
      rd("p2 data", `PORT2_DATA_OFS, 32'hfd, 1'b0);
      rd("p5 sel", `PORT5_FUNCTION_SELECT_OFS, 32'h0, 1'b0);
      rd("p5 dir", `PORT5_DIRECTION_OFS, 32'h0, 1'b0);
      rd("hole", 8'h10, 32'h0, 1'b1);
   endtask : t_reset_vals
   task automatic t_port2;
      wr(`PORT2_DATA_OFS, 32'hffffff06);
      wr(`PORT2_DIRECTION_OFS, 32'h7);
      step(1);
      check("p2 oe", p2_pin_oe_n_o, 3'h0);
      check("p2 out", p2_pin_o, 3'h6);
      wr(`PORT2_DIRECTION_OFS, 32'h2);
      rx_enable_bit_i <= 1'b1;
      step(3);
      // pin 1 reads 0 on the board but stored 1 is returned
      rd("p2 stored", `PORT2_DATA_OFS, 32'hff, 1'b0);
      @(posedge mclk_i);
      tx_select_i <= 1'b1;
      step(1);
      check("p2 oe tx", p2_pin_oe_n_o, 3'h3);
      check("txd", p2_pin_o[2], serial_txd_i);
      for (int c = 0; c < 8; c++) begin
         @(posedge mclk_i);
         {clock_source_hi_i, clock_source_lo_i, clocked_mode_i} <= c[2:0];
         step(3);
         check("sck oe", p2_pin_oe_n_o[0], c[2] || !(c[1] || c[0]));
         check("sck in", serial_clk_in_o, c[2]);
         check("rxd", serial_rxd_o, 1'b0);
         if (p2_pin_oe_n_o[0] === 1'b0) check("sck", p2_pin_o[0], serial_clk_out_i);
      end
      @(posedge mclk_i);
      {tx_select_i, rx_enable_bit_i, clock_source_hi_i, clock_source_lo_i, clocked_mode_i} <= 5'h0;
      wr(`PORT2_DIRECTION_OFS, 32'h0);
      step(3);
      rd("p2 pins", `PORT2_DATA_OFS, 32'hfd, 1'b0);
      check("rxd idle", serial_rxd_o, 1'b1);
   endtask : t_port2
   task automatic t_port5;
      wr(`PORT5_DIRECTION_OFS, 32'hff);
      step(1);
      check("p5 oe", p5_pin_oe_n_o, 8'h00);
      check("p5 out", p5_pin_o, 8'h0f);
      @(posedge mclk_i);
      p5_ext <= 8'h0a;
      wr(`PORT5_FUNCTION_SELECT_OFS, 32'hff);
      step(1);
      check("p5 oe sel", p5_pin_oe_n_o, 8'h3f);
      @(posedge mclk_i);
      p5_out_data_i <= 8'hc0;
      step(3);
      check("p5 od", p5_pin_oe_n_o, 8'hff);
      check("wake", wake_in_n_o, 6'h0a);
      check("trig", conv_trigger_in_n_o, 1'b0);
      check("level", p5_pin_level_o, 8'h0a);
      rd("p5 sel", `PORT5_FUNCTION_SELECT_OFS, 32'hff, 1'b0);
      wr(`PORT5_FUNCTION_SELECT_OFS, 32'h0);
      step(3);
      check("wake off", wake_in_n_o, 6'h3f);
      check("p5 pp", p5_pin_oe_n_o, 8'h00);
      rd("p5 dir", `PORT5_DIRECTION_OFS, 32'h0, 1'b0);
   endtask : t_port5
   task automatic finish_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial begin
      #100000;
      errors++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      step(3);
      t_reset_vals();
      t_port2();
      t_port5();
      finish_test();
   end
endmodule : testbench
